/* pkg/rms_params.svh */
// Constants for the reset mode sequencer
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH
`define RMS_CLK_PERIOD_NS 50
`define RMS_LOCK_MAX_US 10
`define RMS_LOCK_CYC ((`RMS_LOCK_MAX_US * 1000) / `RMS_CLK_PERIOD_NS)
`define RMS_PLL_SETTLE_CYC 64
`define RMS_WD_HOLD_CYC 24
`define RMS_CNT_W 8
`define RMS_STRAP_W 24
`define RMS_WARM_BIT 4
`define RMS_STAT_W 8
`define RMS_SYNC_W 3
`endif

/* pkg/rms_pkg.sv */
// Types for the reset mode sequencer
package rms_pkg;
   typedef enum logic [2:0] {
      RMS_ST_RESET = 3'b000,
      RMS_ST_PLL   = 3'b001,
      RMS_ST_WAIT  = 3'b010,
      RMS_ST_RUN   = 3'b011,
      RMS_ST_WDOG  = 3'b100
   } rms_state_t;
   typedef enum logic [1:0] {
      RMS_MODE_COLD = 2'b00,
      RMS_MODE_WARM = 2'b01,
      RMS_MODE_SOFT = 2'b10
   } rms_mode_t;
endpackage : rms_pkg

/* hw/rms_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rms_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin in, filtered level out
   input wire logic pin,
   output logic level
);
   logic s1_ff, s2_ff, s3_ff, lvl_ff;
   logic nxt_lvl;

   always_comb begin
      nxt_lvl = lvl_ff;
      if (s2_ff == s3_ff) begin
         nxt_lvl = s2_ff;
      end
   end

   // Reset value 0 keeps a reset pin asserted until it is seen high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         lvl_ff <= 1'b0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   assign level = lvl_ff;
endmodule : rms_sync
`default_nettype wire

/* hw/rms_top.sv */
// Reset mode sequencer: cold, warm and watchdog soft reset with strap capture
// Functional notes
// - Three reset modes exist: cold, hardware warm, and soft reset from the internal watchdog.
// - A cold reset returns every module, including clock synthesis, to its default state; here strap_config and the boundary-scan logic keep their values.
// - The clocks-settled output rises within 10 us of hard reset release and gates boot.
// - A warm reset restores everything except clock synthesis, so it finishes sooner.
// - Timer status bit 4 is set by a watchdog soft reset and cleared by warm or cold resets.
// - Boundary-scan logic keeps its state however long the test clock is halted.
// - Boundary-scan inputs are sampled on the rising test clock edge, output updated on falling.
// - Clocks-settled drops at once on watchdog, within four clocks after a reset pin falls, and stays low about 24 clocks after watchdog.
`timescale 1ns/100ps
`default_nettype none
`include "rms_params.svh"
module rms_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Board reset pins
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n,
   // Internal watchdog request, same clock
   input wire logic watchdog_event,
   // Configuration straps
   input wire logic [`RMS_STRAP_W-1:0] strap_address_bus,
   // Sequencer outputs
   output logic clocks_settled,
   output logic boot_enable,
   output logic pll_reset_n,
   output logic core_reset_n,
   output logic [`RMS_STRAP_W-1:0] strap_config,
   output logic [`RMS_STAT_W-1:0] timer_status,
   output logic [1:0] last_reset_mode,
   // Boundary-scan port
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic test_reset_n,
   output logic tdo,
   output logic tdo_oe_n
);
   logic rst_a_ff, rst_b_ff;
   logic por_lvl, hrd_lvl;
   rms_pkg::rms_state_t state_ff, nxt_state;
   logic [`RMS_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [15:0] lock_ff, nxt_lock;
   logic soft_ff, nxt_soft;
   logic pll_ok_ff, nxt_pll_ok;
   logic [`RMS_STRAP_W-1:0] strap_ff, nxt_strap;
   rms_pkg::rms_mode_t mode_ff, nxt_mode;
   logic [3:0] jt_cap_ff;
   logic tdo_ff;

   // Reset release through two flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_a_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_b_ff <= rst_a_ff;
      end
   end

   rms_sync u_por_sync (
      .clk(mclk),
      .rst_n(rst_b_ff),
      .pin(power_on_reset_n),
      .level(por_lvl)
   );

   rms_sync u_hrd_sync (
      .clk(mclk),
      .rst_n(rst_b_ff),
      .pin(hard_reset_n),
      .level(hrd_lvl)
   );

   function automatic logic cnt_done(input logic [`RMS_CNT_W-1:0] c, input logic [`RMS_CNT_W-1:0] lim);
      cnt_done = (c >= lim);
   endfunction : cnt_done

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_lock = lock_ff;
      nxt_soft = soft_ff;
      nxt_pll_ok = pll_ok_ff;
      nxt_strap = strap_ff;
      nxt_mode = mode_ff;
      if (!por_lvl) begin
         // Cold: clock synthesis lost as well
         nxt_state = rms_pkg::RMS_ST_RESET;
         nxt_pll_ok = 1'b0;
         nxt_soft = 1'b0;
         nxt_mode = rms_pkg::RMS_MODE_COLD;
         nxt_cnt = '0;
         nxt_lock = '0;
      end else if (!hrd_lvl) begin
         // Warm when clock synthesis already settled
         nxt_state = rms_pkg::RMS_ST_RESET;
         nxt_soft = 1'b0;
         if (pll_ok_ff) begin
            nxt_mode = rms_pkg::RMS_MODE_WARM;
         end
         nxt_cnt = '0;
         nxt_lock = '0;
         // Straps tracked while hard reset is low and power-on reset is high, frozen on release
         nxt_strap = strap_address_bus;
      end else if (watchdog_event && state_ff == rms_pkg::RMS_ST_RUN) begin
         nxt_state = rms_pkg::RMS_ST_WDOG;
         nxt_soft = 1'b1;
         nxt_mode = rms_pkg::RMS_MODE_SOFT;
         nxt_cnt = '0;
      end else begin
         case (state_ff)
            rms_pkg::RMS_ST_RESET: begin
               nxt_cnt = '0;
               nxt_lock = '0;
               nxt_state = pll_ok_ff ? rms_pkg::RMS_ST_WAIT : rms_pkg::RMS_ST_PLL;
            end
            rms_pkg::RMS_ST_PLL: begin
               nxt_lock = lock_ff + 16'h0001;
               nxt_cnt = cnt_ff + 8'h01;
               if (cnt_done(cnt_ff, 8'(`RMS_PLL_SETTLE_CYC))) begin
                  nxt_pll_ok = 1'b1;
                  nxt_state = rms_pkg::RMS_ST_RUN;
               end
            end
            rms_pkg::RMS_ST_WAIT: begin
               // Warm path skips clock settling, so it finishes sooner
               nxt_state = rms_pkg::RMS_ST_RUN;
            end
            rms_pkg::RMS_ST_WDOG: begin
               nxt_cnt = cnt_ff + 8'h01;
               if (cnt_done(cnt_ff, 8'(`RMS_WD_HOLD_CYC - 1))) begin
                  nxt_state = rms_pkg::RMS_ST_RUN;
               end
            end
            default: begin
               nxt_state = state_ff;
            end
         endcase
         // Safety bound keeps the settle time under the published maximum
         if (state_ff == rms_pkg::RMS_ST_PLL && lock_ff >= 16'(`RMS_LOCK_CYC - 2)) begin
            nxt_pll_ok = 1'b1;
            nxt_state = rms_pkg::RMS_ST_RUN;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         state_ff <= rms_pkg::RMS_ST_RESET;
         cnt_ff <= '0;
         lock_ff <= '0;
         soft_ff <= 1'b0;
         pll_ok_ff <= 1'b0;
         strap_ff <= '0;
         mode_ff <= rms_pkg::RMS_MODE_COLD;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         lock_ff <= nxt_lock;
         soft_ff <= nxt_soft;
         pll_ok_ff <= nxt_pll_ok;
         strap_ff <= nxt_strap;
         mode_ff <= nxt_mode;
      end
   end

   // Drops combinationally on watchdog_event; reset pins reach it through the synchronisers
   assign clocks_settled = (state_ff == rms_pkg::RMS_ST_RUN) && por_lvl && hrd_lvl && !watchdog_event;
   assign boot_enable = clocks_settled;
   assign pll_reset_n = pll_ok_ff || (state_ff == rms_pkg::RMS_ST_PLL);
   assign core_reset_n = clocks_settled;
   assign strap_config = strap_ff;
   assign last_reset_mode = mode_ff;

   always_comb begin
      timer_status = '0;
      timer_status[`RMS_WARM_BIT] = soft_ff;
   end

   // Boundary scan: capture on rising TCK, launch on falling; no timeout on TCK
   always_ff @(posedge tck or negedge test_reset_n) begin
      if (!test_reset_n) begin
         jt_cap_ff <= '0;
      end else begin
         jt_cap_ff <= {jt_cap_ff[2:0] ^ {3{tms}}, tdi};
      end
   end

   always_ff @(negedge tck or negedge test_reset_n) begin
      if (!test_reset_n) begin
         tdo_ff <= 1'b0;
      end else begin
         tdo_ff <= jt_cap_ff[3];
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe_n = !test_reset_n;
endmodule : rms_top
`default_nettype wire

/* test/rms_top_props.sv */
// Checker for the reset mode sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "rms_params.svh"
module rms_top_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Reset causes
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n,
   input wire logic watchdog_event,
   input wire logic test_reset_n,
   // Sequencer outputs
   input wire logic clocks_settled,
   input wire logic boot_enable,
   input wire logic core_reset_n,
   input wire logic pll_reset_n,
   input wire logic [`RMS_STRAP_W-1:0] strap_config,
   input wire logic [`RMS_STAT_W-1:0] timer_status,
   input wire logic [1:0] last_reset_mode,
   input wire logic tdo_oe_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   AST_WD_DROP: assert property (watchdog_event |-> !clocks_settled)
      else $error("settled high during watchdog");
   AST_BOOT_GATE: assert property (boot_enable == clocks_settled && core_reset_n == clocks_settled)
      else $error("boot not gated by settled");
   AST_HARD_DROP: assert property ($fell(hard_reset_n) |-> ##[0:4] !clocks_settled)
      else $error("settled kept after hard reset");
   AST_SETTLE_MAX: assert property ($rose(hard_reset_n) ##1 hard_reset_n[*8] |-> ##[0:190] clocks_settled)
      else $error("settled too late");
   AST_FLAG: assert property ($rose(clocks_settled) |-> timer_status[`RMS_WARM_BIT] == (last_reset_mode == 2'h2))
      else $error("soft flag wrong");
   AST_STRAP_HOLD: assert property (clocks_settled && $past(clocks_settled) |-> $stable(strap_config))
      else $error("straps moved while settled");
   AST_WD_HOLD: assert property (clocks_settled ##1 watchdog_event |-> (!clocks_settled)[*8] ##[8:40] clocks_settled)
      else $error("watchdog hold wrong");
   AST_PLL_KEEP: assert property (power_on_reset_n[*6] ##0 $past(pll_reset_n) |-> pll_reset_n)
      else $error("clock synthesis reset without cold");
   AST_TRST: assert property ((!test_reset_n)[*2] |-> tdo_oe_n)
      else $error("scan output driven in reset");
   cover property ($rose(clocks_settled) && last_reset_mode == 2'h0);
   cover property ($rose(clocks_settled) && last_reset_mode == 2'h1);
   cover property ($rose(clocks_settled) && last_reset_mode == 2'h2);
endmodule : rms_top_props
bind rms_top rms_top_props u_props (.mclk, .nrst, .power_on_reset_n, .hard_reset_n, .watchdog_event,
   .test_reset_n, .clocks_settled, .boot_enable, .core_reset_n, .pll_reset_n, .strap_config,
   .timer_status, .last_reset_mode, .tdo_oe_n);
`default_nettype wire

/* test/rms_board.sv */
// Board reset supervisor model driving reset pins and straps
`timescale 1ns/100ps
`default_nettype none
`include "rms_params.svh"
module rms_board (
   // Clock and device status
   input wire logic mclk,
   input wire logic clocks_settled,
   // Reset pins and straps
   output logic power_on_reset_n = 1'b0,
   output logic hard_reset_n = 1'b0,
   output logic [`RMS_STRAP_W-1:0] strap_address_bus = '0
);
   logic [`RMS_STRAP_W-1:0] cfg = '0;
   // Straps are not held once settled, so they change every cycle then
   always @(negedge mclk) begin
      strap_address_bus <= clocks_settled ? ~strap_address_bus : cfg;
   end
   task automatic reset_pins(input logic cold, input logic [`RMS_STRAP_W-1:0] s);
      cfg = s;
      @(negedge mclk);
      power_on_reset_n <= !cold;
      hard_reset_n <= 1'b0;
      repeat (cold ? 40 : 10) @(negedge mclk);
      power_on_reset_n <= 1'b1;
      @(negedge mclk);
      hard_reset_n <= 1'b1;
   endtask : reset_pins
endmodule : rms_board
`default_nettype wire

/* test/rms_top_bench.sv */
// Testbench for the reset mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "rms_params.svh"
module rms_top_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic watchdog_event = 1'b0;
   logic tck = 1'b0;
   logic tms = 1'b0;
   logic tdi = 1'b0;
   logic test_reset_n = 1'b0;
   logic por_n, hard_n, settled, boot, pll_n, core_n, tdo, tdo_oe_n;
   logic [`RMS_STRAP_W-1:0] straps, cfg;
   logic [7:0] status;
   logic [1:0] mode;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int cold_lat = 300;
   rms_board board (.mclk(mclk), .clocks_settled(settled), .power_on_reset_n(por_n),
      .hard_reset_n(hard_n), .strap_address_bus(straps));
   rms_top dut (.mclk(mclk), .nrst(nrst), .power_on_reset_n(por_n), .hard_reset_n(hard_n),
      .watchdog_event(watchdog_event), .strap_address_bus(straps), .clocks_settled(settled),
      .boot_enable(boot), .pll_reset_n(pll_n), .core_reset_n(core_n), .strap_config(cfg),
      .timer_status(status), .last_reset_mode(mode), .tck(tck), .tms(tms), .tdi(tdi),
      .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   initial begin
      forever #25 mclk = ~mclk;
   end
   // Whole run is under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic settle_wait(output int n);
      n = 0;
      while (settled !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
   endtask : settle_wait
   task automatic t_pins(input logic cold, input logic [23:0] s);
      int n;
      board.reset_pins(cold, s);
      chk(pll_n === !cold, "clock synthesis reset state");
      settle_wait(n);
      chk(n <= 200 && (cold || n < cold_lat), "settle latency");
      chk(boot === 1'b1 && core_n === 1'b1, "boot not released after settle");
      if (cold) cold_lat = n;
      chk(cfg === s, "straps not captured");
      chk(mode === (cold ? rms_pkg::RMS_MODE_COLD : rms_pkg::RMS_MODE_WARM), "mode");
      chk(status === 8'h00, "soft flag not cleared");
   endtask : t_pins
   task automatic t_soft;
      int n;
      @(negedge mclk);
      watchdog_event = 1'b1;
      @(negedge mclk);
      watchdog_event = 1'b0;
      chk(settled === 1'b0 && boot === 1'b0 && core_n === 1'b0, "settled kept on watchdog");
      settle_wait(n);
      chk(n >= 16 && n <= 40, "watchdog hold length");
      chk(mode === rms_pkg::RMS_MODE_SOFT && status === 8'h10, "soft flag");
   endtask : t_soft
   task automatic t_scan;
      logic v;
      logic [3:0] hist;
      logic [7:0] pat;
      hist = 4'h0;
      pat = 8'hb4;
      repeat (2) @(negedge mclk);
      chk(tdo_oe_n === 1'b1, "scan output driven in reset");
      test_reset_n = 1'b1;
      // Data set a full cycle before the test clock rises, held three cycles after it
      repeat (8) begin
         @(negedge mclk);
         tdi = pat[7];
         pat = {pat[6:0], 1'b0};
         @(negedge mclk);
         v = tdo;
         tck = 1'b1;
         hist = {hist[2:0], tdi};
         @(negedge mclk);
         chk(tdo === v, "scan output moved on rising edge");
         tck = 1'b0;
         @(negedge mclk);
         chk(tdo === hist[3], "scan output wrong after falling edge");
      end
      v = tdo;
      repeat (40) @(negedge mclk);
      chk(tdo === v, "scan state lost while clock halted");
      @(negedge mclk);
      chk(tdo_oe_n === 1'b0, "scan output not driven");
   endtask : t_scan
   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      t_pins(1'b1, 24'ha5c3e1);
      t_pins(1'b0, 24'h5a3c1e);
      t_soft();
      t_pins(1'b0, 24'h0f00f0);
      t_soft();
      t_pins(1'b1, 24'h123456);
      t_scan();
      conclude();
   end
endmodule : rms_top_bench
`default_nettype wire
